//--- core/vw_watchdog.sv
`timescale 1ns/100ps
module vw_watchdog
  import vw_pkg::*;
#(
  parameter int TICK_CYC = vw_pkg::TICK_CYCLES,
  parameter int DEB_CYC = vw_pkg::DEB_CYCLES,
  parameter int BUZZ_CYC = vw_pkg::BUZZ_HALF_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic vigilance_pedal,
  input wire logic sanding_switch,
  input wire logic vigilance_reset_button,
  input wire logic vigilance_ack_button,
  input wire logic [7:0] traction_brake_effort_throttle,
  input wire logic [15:0] speed,
  input wire logic [7:0] brake_cylinder_pressure,
  output logic cab_alarm_buzzer,
  output logic vigilance_warning_lamp,
  output logic emergency_brake,
  output logic traction_cutoff,
  output logic [7:0] brake_pipe_pressure,
  output logic full_brake_cylinder,
  output logic irq
);
  import vw_pkg::*;

  // Whole state of the block
  typedef struct packed {
    logic [3:0] btn_s1;          // First sync stage, read by second only
    logic [3:0] btn_s2;          // Second sync stage
    logic [3:0] lvl;             // Debounced levels
    logic [3:0][DEB_W-1:0] deb;  // Per-button stability counters
    logic [3:0] prs;             // Press pulses
    logic [3:0] rls;             // Release pulses
    logic [7:0] thr_s1;
    logic [7:0] thr_s2;
    logic [7:0] thr_prev;        // Throttle sample at previous tick
    logic [15:0] spd_s1;
    logic [15:0] spd_s2;
    logic [7:0] bc_s1;
    logic [7:0] bc_s2;
    logic [TICK_W-1:0] tcnt;     // Second prescaler
    logic tick;                  // One-cycle second pulse
    logic [BUZZ_W-1:0] bcnt;     // Tone half-period counter
    logic tone;
    logic buzz;
    vw_state_t st;
    logic [7:0] sec;             // Seconds in current interval
    logic [7:0] lock;            // Seconds since penalty
    logic dm;                    // Dead-man mode
    logic rs_ack;                // Recovery: ack seen with throttle at zero
    logic rs_ped;                // Recovery: pedal pressed after ack
    logic ctrl_en;
    logic [3:0] int_st;
    logic [3:0] int_mask;
    logic [31:0] rdata;
  } vw_s_t;

  vw_s_t s_q;
  vw_s_t s_d;
  logic active;
  logic thr_act;
  logic act;
  logic ack;
  logic [3:0] ev;
  logic [3:0] w1c;
  logic wr;
  logic mapped;
  logic [8:0] thr_diff;
  logic [3:0] btn_in;

  assign btn_in = {vigilance_ack_button, vigilance_reset_button,
                   sanding_switch, vigilance_pedal};

  // Zero-wait slave; error only on unmapped access phase
  assign pready = 1'b1;
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) ||
                  (paddr == OFS_INT_STATUS) || (paddr == OFS_INT_MASK);
  assign pslverr = psel && penable && !mapped;
  assign wr = psel && penable && pwrite && mapped;
  assign prdata = s_q.rdata;

  // Penalty outputs decode straight from the state flop
  assign vigilance_warning_lamp = (s_q.st == VW_ALARM);
  assign emergency_brake = (s_q.st == VW_PEN);
  assign traction_cutoff = (s_q.st == VW_PEN);
  assign brake_pipe_pressure = (s_q.st == VW_PEN) ? BP_PENALTY : BP_RUN;
  assign full_brake_cylinder = (s_q.st == VW_PEN);
  assign cab_alarm_buzzer = s_q.buzz;
  assign irq = |(s_q.int_st & s_q.int_mask);

  // Next-state logic for the whole block
  always_comb begin
    s_d = s_q;
    ev = 4'h0;
    w1c = 4'h0;
    // Two-flop synchronisers on every pin input
    s_d.btn_s1 = btn_in;
    s_d.btn_s2 = s_q.btn_s1;
    s_d.thr_s1 = traction_brake_effort_throttle;
    s_d.thr_s2 = s_q.thr_s1;
    s_d.spd_s1 = speed;
    s_d.spd_s2 = s_q.spd_s1;
    s_d.bc_s1 = brake_cylinder_pressure;
    s_d.bc_s2 = s_q.bc_s1;
    // Debounce: level follows only after a stable run
    for (int i = 0; i < 4; i++) begin
      s_d.prs[i] = 1'b0;
      s_d.rls[i] = 1'b0;
      if (s_q.btn_s2[i] == s_q.lvl[i]) begin
        s_d.deb[i] = '0;
      end else if (s_q.deb[i] == DEB_W'(DEB_CYC - 1)) begin
        s_d.deb[i] = '0;
        s_d.lvl[i] = s_q.btn_s2[i];
        s_d.prs[i] = s_q.btn_s2[i];
        s_d.rls[i] = !s_q.btn_s2[i];
      end else begin
        s_d.deb[i] = s_q.deb[i] + DEB_W'(1);
      end
    end
    // Second prescaler
    if (s_q.tcnt == TICK_W'(TICK_CYC - 1)) begin
      s_d.tcnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.tcnt = s_q.tcnt + TICK_W'(1);
      s_d.tick = 1'b0;
    end
    // Tone generator runs freely; gating keeps it intermittent
    if (s_q.bcnt == BUZZ_W'(BUZZ_CYC - 1)) begin
      s_d.bcnt = '0;
      s_d.tone = !s_q.tone;
    end else begin
      s_d.bcnt = s_q.bcnt + BUZZ_W'(1);
    end
    // Sound only in the first half of each second
    s_d.buzz = (s_q.st == VW_ALARM) && s_q.tone &&
               (s_q.tcnt < TICK_W'(TICK_CYC / 2));
    // Supervision enable from motion and released brakes
    active = s_q.ctrl_en && (s_q.spd_s2 > SPEED_MIN) &&
             (s_q.bc_s2 < BC_REL_MAX);
    // Throttle sampled once a second; signed percent difference
    thr_diff = {s_q.thr_s2[7], s_q.thr_s2} - {s_q.thr_prev[7], s_q.thr_prev};
    if (s_q.tick) begin
      s_d.thr_prev = s_q.thr_s2;
    end
    thr_act = s_q.tick && (s_q.spd_s2 > SPEED_MIN) &&
              ((thr_diff[8] ? 9'(-thr_diff) : thr_diff) >= THR_STEP);
    // Valid actions; dead-man narrows them to pedal and reset
    if (s_q.dm) begin
      act = s_q.prs[BTN_PEDAL] || s_q.prs[BTN_RESET];
      ack = s_q.prs[BTN_PEDAL] || s_q.prs[BTN_RESET];
    end else begin
      act = s_q.prs[BTN_PEDAL] || s_q.prs[BTN_SAND] ||
            s_q.prs[BTN_RESET] || thr_act;
      ack = s_q.rls[BTN_PEDAL] || s_q.rls[BTN_ACK];
    end
    // Dead-man entry on any pedal release; pedal press or reset clears it
    if (s_q.rls[BTN_PEDAL]) begin
      s_d.dm = 1'b1;
      ev[EV_DEADMAN] = !s_q.dm;
    end else if (s_q.dm && act) begin
      s_d.dm = 1'b0;
    end
    // Supervision sequence
    unique case (s_q.st)
      VW_IDLE: begin
        s_d.sec = '0;
        if (active) begin
          s_d.st = VW_SUP;
        end
      end
      VW_SUP: begin
        if (!active) begin
          s_d.st = VW_IDLE;
        end else if (act) begin
          s_d.sec = '0;
        end else if (s_q.tick) begin
          if (s_q.sec == SUP_SECS - 8'h01) begin
            s_d.st = VW_ALARM;
            s_d.sec = '0;
            ev[EV_ALARM] = 1'b1;
          end else begin
            s_d.sec = s_q.sec + 8'h01;
          end
        end
      end
      VW_ALARM: begin
        if (!active) begin
          s_d.st = VW_IDLE;
        end else if (ack) begin
          s_d.st = VW_SUP;
          s_d.sec = '0;
        end else if (s_q.tick) begin
          if (s_q.sec == ACK_SECS - 8'h01) begin
            s_d.st = VW_PEN;
            s_d.lock = '0;
            s_d.rs_ack = 1'b0;
            s_d.rs_ped = 1'b0;
            ev[EV_PENALTY] = 1'b1;
          end else begin
            s_d.sec = s_q.sec + 8'h01;
          end
        end
      end
      VW_PEN: begin
        s_d.sec = '0;
        // Lockout counter saturates at its limit
        if (s_q.tick && s_q.lock != LOCK_SECS) begin
          s_d.lock = s_q.lock + 8'h01;
        end
        if (s_q.lock < LOCK_SECS) begin
          s_d.rs_ack = 1'b0;
          s_d.rs_ped = 1'b0;
        end else if (s_q.thr_s2 != 8'h00) begin
          s_d.rs_ack = 1'b0;
          s_d.rs_ped = 1'b0;
        end else if (s_q.prs[BTN_ACK]) begin
          s_d.rs_ack = 1'b1;
          s_d.rs_ped = 1'b0;
        end else if (s_q.rs_ack && s_q.prs[BTN_PEDAL]) begin
          s_d.rs_ped = 1'b1;
        end else if (s_q.rs_ped && s_q.rls[BTN_PEDAL]) begin
          s_d.st = VW_IDLE;
          // Closing pedal release leaves dead-man mode set
          ev[EV_RECOVER] = 1'b1;
        end
      end
    endcase
    // Register writes
    if (wr && paddr == OFS_CTRL) begin
      s_d.ctrl_en = pwdata[0];
    end
    if (wr && paddr == OFS_INT_MASK) begin
      s_d.int_mask = pwdata[3:0];
    end
    if (wr && paddr == OFS_INT_STATUS) begin
      w1c = pwdata[3:0];
    end
    // A new event wins over a clear in the same cycle
    s_d.int_st = (s_q.int_st & ~w1c) | ev;
    // Read data captured in the setup cycle
    if (psel && !penable) begin
      unique case (paddr)
        OFS_CTRL: s_d.rdata = {31'h0, s_q.ctrl_en};
        OFS_STATUS: s_d.rdata = {8'h00, s_q.lock, s_q.sec, 5'h00, s_q.dm, s_q.st};
        OFS_INT_STATUS: s_d.rdata = {28'h0, s_q.int_st};
        OFS_INT_MASK: s_d.rdata = {28'h0, s_q.int_mask};
        default: s_d.rdata = 32'h0;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.st <= VW_IDLE;
      s_q.ctrl_en <= CTRL_EN_RST;
      s_q.int_mask <= INT_MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Alarm only after a full supervision interval
  property p_alarm_after_sup;
    (s_q.st == VW_ALARM) && ($past(s_q.st) == VW_SUP) |->
      $past(s_q.sec) == SUP_SECS - 8'h01 && $past(s_q.tick);
  endproperty
  a_alarm_after_sup: assert property (p_alarm_after_sup)
    else $error("alarm raised before interval end");

  // Lamp lights only from supervision while active
  property p_lamp_rise;
    $rose(vigilance_warning_lamp) |-> $past(s_q.st) == VW_SUP && $past(active);
  endproperty
  a_lamp_rise: assert property (p_lamp_rise)
    else $error("lamp lit without timeout");

  // Penalty only after the acknowledge window
  property p_pen_after_ack;
    $rose(emergency_brake) |-> $past(s_q.st) == VW_ALARM &&
      $past(s_q.sec) == ACK_SECS - 8'h01;
  endproperty
  a_pen_after_ack: assert property (p_pen_after_ack)
    else $error("penalty outside acknowledge window");

  // No recovery before lockout ends
  property p_lockout;
    $fell(emergency_brake) |-> $past(s_q.lock) == LOCK_SECS;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("penalty released during lockout");

  // Penalty commands the brake pipe level and full cylinder
  property p_pen_brake;
    traction_cutoff |-> brake_pipe_pressure == BP_PENALTY && full_brake_cylinder
      && emergency_brake;
  endproperty
  a_pen_brake: assert property (p_pen_brake)
    else $error("penalty brake command wrong");

  // Inactive supervision drops to idle
  property p_inactive;
    !active && s_q.st != VW_PEN |=> s_q.st == VW_IDLE;
  endproperty
  a_inactive: assert property (p_inactive)
    else $error("supervision ran while inactive");

  // Action restarts the count
  property p_restart;
    s_q.st == VW_SUP && active && act |=> s_q.sec == 8'h00 && s_q.st == VW_SUP;
  endproperty
  a_restart: assert property (p_restart)
    else $error("action did not restart count");

  // Pedal release enters dead-man mode
  property p_deadman;
    s_q.rls[BTN_PEDAL] |=> s_q.dm ##1 s_q.int_st[EV_DEADMAN] || s_q.dm == 1'b0;
  endproperty
  a_deadman: assert property (p_deadman)
    else $error("dead-man mode not entered");

  // Sanding or throttle cannot restart in dead-man mode
  property p_dm_throttle;
    s_q.st == VW_SUP && active && s_q.dm && !s_q.prs[BTN_PEDAL] &&
      !s_q.prs[BTN_RESET] && s_q.sec != SUP_SECS - 8'h01 |=>
      s_q.sec == $past(s_q.sec) + {7'h00, $past(s_q.tick)};
  endproperty
  a_dm_throttle: assert property (p_dm_throttle)
    else $error("dead-man restarted by other control");

  // Acknowledge returns to a fresh interval
  property p_ack;
    s_q.st == VW_ALARM && active && ack |=> s_q.st == VW_SUP && s_q.sec == 8'h00;
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge not honoured");

  // Debounced pedal level changes only after a stable run
  property p_debounce;
    $changed(s_q.lvl[BTN_PEDAL]) |-> $past(s_q.deb[BTN_PEDAL]) == DEB_W'(DEB_CYC - 1);
  endproperty
  a_debounce: assert property (p_debounce)
    else $error("pedal level changed before debounce");
endmodule

//--- core/vw_pkg.sv
package vw_pkg;
  // Clock and time base
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_S;
  localparam int DEB_MS = 10;
  localparam int DEB_CYCLES = (CLK_HZ / 1000) * DEB_MS;
  localparam int BUZZ_HZ = 546;
  localparam int BUZZ_HALF_CYCLES = CLK_HZ / (2 * BUZZ_HZ);
  // Counter widths sized for the default counts
  localparam int TICK_W = 27;
  localparam int DEB_W = 24;
  localparam int BUZZ_W = 17;
  // Supervision intervals in whole seconds
  localparam logic [7:0] SUP_SECS = 8'h3C;
  localparam logic [7:0] ACK_SECS = 8'h08;
  localparam logic [7:0] LOCK_SECS = 8'hB4;
  // Analog thresholds: speed in 0.1 km/h, pressures in 0.1 kg/cm2, throttle in %
  localparam logic [15:0] SPEED_MIN = 16'h000F;
  localparam logic [7:0] BC_REL_MAX = 8'h0A;
  localparam logic [8:0] THR_STEP = 9'h003;
  localparam logic [7:0] BP_PENALTY = 8'h1E;
  localparam logic [7:0] BP_RUN = 8'h00;
  // Button bit positions
  localparam int BTN_PEDAL = 0;
  localparam int BTN_SAND = 1;
  localparam int BTN_RESET = 2;
  localparam int BTN_ACK = 3;
  // Interrupt bit positions
  localparam int EV_ALARM = 0;
  localparam int EV_PENALTY = 1;
  localparam int EV_DEADMAN = 2;
  localparam int EV_RECOVER = 3;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_STATUS = 8'h08;
  localparam logic [7:0] OFS_INT_MASK = 8'h0C;
  // Reset values
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [3:0] INT_MASK_RST = 4'h0;
  // Supervision states, Gray along idle-supervise-alarm-penalty
  typedef enum logic [1:0] {
    VW_IDLE = 2'b00,
    VW_SUP = 2'b01,
    VW_ALARM = 2'b11,
    VW_PEN = 2'b10
  } vw_state_t;
endpackage

//--- dv/vw_crew_model.sv
`timescale 1ns/100ps
// Crew controls and brake system facing the watchdog
module vw_crew_model (
  input wire logic pclk,
  input wire logic full_brake_cylinder,
  output logic vigilance_pedal,
  output logic sanding_switch,
  output logic vigilance_reset_button,
  output logic vigilance_ack_button,
  output logic [7:0] traction_brake_effort_throttle,
  output logic [15:0] speed,
  output logic [7:0] brake_cylinder_pressure
);
  import vw_pkg::*;
  logic [3:0] btn_q = 4'h1; // Pressed buttons, pedal held
  logic [7:0] bc_q = 8'h00; // Service brake pressure
  // Each button on its own pin
  assign vigilance_pedal = btn_q[BTN_PEDAL];
  assign sanding_switch = btn_q[BTN_SAND];
  assign vigilance_reset_button = btn_q[BTN_RESET];
  assign vigilance_ack_button = btn_q[BTN_ACK];
  // Cylinder fills hard while a penalty lasts
  assign brake_cylinder_pressure = full_brake_cylinder ? 8'h32 : bc_q;
  // Standing train, throttle at zero
  initial begin
    traction_brake_effort_throttle = 8'h00;
    speed = 16'h0000;
  end
  // Held well past the debounce span
  task automatic set_btn(input int i, input logic v);
    @(posedge pclk);
    btn_q[i] <= v;
    repeat (20) @(posedge pclk);
  endtask
  // Full press then release
  task automatic tap(input int i);
    set_btn(i, 1'b1);
    set_btn(i, 1'b0);
  endtask
  // Throttle moves in one step
  task automatic set_thr(input logic [7:0] v);
    @(posedge pclk);
    traction_brake_effort_throttle <= v;
  endtask
  // Speed and service brake together
  task automatic set_run(input logic [15:0] s, input logic [7:0] b);
    @(posedge pclk);
    speed <= s;
    bc_q <= b;
  endtask
  // Crew walk after a penalty brake
  task automatic recover;
    set_thr(8'h00);
    tap(BTN_ACK);
    tap(BTN_PEDAL);
  endtask
endmodule

//--- dv/test_vigilance_watchdog.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) \
  begin \
    checks++; \
    if ((e) !== (g)) begin \
      failures++; \
      $display("mismatch %s expected %h seen %h", nm, e, g); \
    end \
  end
module test_vigilance_watchdog;
  import vw_pkg::*;
  localparam int T = 100; // Cycles per tick, shortened
  localparam logic [12:0] LAMP = 13'h0800; // Warning lamp alone
  localparam logic [12:0] IRQB = 13'h1000; // Interrupt alone
  localparam logic [12:0] PEN = 13'h071E; // Brake, cut-off, full cylinder, penalty pipe
  typedef struct {string nm; logic [32:0] e; logic [32:0] m;} vw_note_t;
  vw_note_t q[$]; // Expected results, oldest first
  int checks = 0;
  int failures = 0;
  int buzz_edges = 0; // Buzzer toggles seen
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic vigilance_pedal;
  logic sanding_switch;
  logic vigilance_reset_button;
  logic vigilance_ack_button;
  logic [7:0] traction_brake_effort_throttle;
  logic [15:0] speed;
  logic [7:0] brake_cylinder_pressure;
  logic cab_alarm_buzzer;
  logic vigilance_warning_lamp;
  logic emergency_brake;
  logic traction_cutoff;
  logic [7:0] brake_pipe_pressure;
  logic full_brake_cylinder;
  logic irq;
  logic [12:0] outs; // Watched output levels
  logic [12:0] last_q = 13'h0000;
  logic buzz_q = 1'b0;
  assign outs = {irq, vigilance_warning_lamp, emergency_brake, traction_cutoff,
    full_brake_cylinder, brake_pipe_pressure};
  vw_watchdog #(.TICK_CYC(T), .DEB_CYC(4), .BUZZ_CYC(3)) i_vw_watchdog (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .vigilance_pedal,
    .sanding_switch, .vigilance_reset_button, .vigilance_ack_button,
    .traction_brake_effort_throttle, .speed, .brake_cylinder_pressure, .cab_alarm_buzzer,
    .vigilance_warning_lamp, .emergency_brake, .traction_cutoff, .brake_pipe_pressure,
    .full_brake_cylinder, .irq);
  vw_crew_model i_vw_crew_model (.pclk, .full_brake_cylinder, .vigilance_pedal,
    .sanding_switch, .vigilance_reset_button, .vigilance_ack_button,
    .traction_brake_effort_throttle, .speed, .brake_cylinder_pressure);
  // 100 MHz
  always #5 pclk = ~pclk;
  // Verdict and end of run
  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Oldest note against a result; no note means an unexpected change
  task automatic take(input logic [32:0] got);
    vw_note_t n;
    n = '{"unexpected", ~got, {33{1'b1}}};
    if (q.size() > 0)
      n = q.pop_front();
    `CHK(n.nm, n.e & n.m, got & n.m)
  endtask
  // Results: finished bus transfers and output changes
  always @(posedge pclk) begin
    if (psel && penable && pready)
      take({pslverr, prdata});
    if (presetn && outs !== last_q)
      take({20'h00000, outs});
    if (cab_alarm_buzzer !== buzz_q)
      buzz_edges++;
    last_q <= outs;
    buzz_q <= cab_alarm_buzzer;
  end
  task automatic note(input string nm, input logic [32:0] e, input logic [32:0] m);
    q.push_back('{nm, e, m});
  endtask
  // One bus transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] m);
    note(nm, {1'b0, e}, {1'b1, m});
    apb(1'b0, a, 32'h00000000);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    note("pslverr", 33'h000000000, 33'h100000000);
    apb(1'b1, a, d);
  endtask
  // Bounded wait for every note to be used
  task automatic settle(input int win);
    int n;
    for (n = 0; n < win && q.size() > 0; n++)
      @(posedge pclk);
    `CHK("wait", 1'b1, q.size() == 0)
    q.delete();
  endtask
  // Silence first, so an early change shows as unexpected
  task automatic expect_out(input string nm, input logic [12:0] v, input int quiet,
    input int win);
    repeat (quiet) @(posedge pclk);
    note(nm, {20'h00000, v}, {33{1'b1}});
    settle(win);
  endtask
  // Main sequence
  initial begin
    logic [7:0] ua;
    void'($urandom(7883));
    ua = 8'(8'h10 + 4 * ($urandom % 60));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd("enable", OFS_CTRL, 32'h1, 32'h1);
    rd("mask", OFS_INT_MASK, 32'h0, 32'hF);
    rd("state", OFS_STATUS, 32'h0, 32'h3);
    note("unmapped", 33'h100000000, {33{1'b1}});
    apb(1'b0, ua, 32'h00000000);
    note("unmapped write", 33'h100000000, 33'h100000000);
    apb(1'b1, ua, $urandom);
    // Speed at the limit, then brakes not released
    i_vw_crew_model.set_run(SPEED_MIN, 8'h00);
    repeat (65 * T) @(posedge pclk);
    i_vw_crew_model.set_run(16'h03E8, BC_REL_MAX);
    repeat (65 * T) @(posedge pclk);
    // Moving with brakes off, but supervision switched off
    wr(OFS_CTRL, 32'h0);
    rd("disabled", OFS_CTRL, 32'h0, 32'h1);
    i_vw_crew_model.set_run(16'(16 + $urandom % 1000), 8'h00);
    repeat (65 * T) @(posedge pclk);
    wr(OFS_CTRL, 32'h1);
    // Each action restarts the cycle
    for (int k = 0; k < 3; k++) begin
      repeat (40 * T) @(posedge pclk);
      if (k == 1)
        i_vw_crew_model.set_thr(THR_STEP[7:0]);
      else
        i_vw_crew_model.tap(k == 0 ? BTN_SAND : BTN_RESET);
    end
    `CHK("buzzer idle", 0, buzz_edges)
    expect_out("alarm", LAMP, 58 * T, 4 * T);
    repeat (T) @(posedge pclk);
    `CHK("buzzer", 1'b1, buzz_edges > 8)
    rd("alarm event", OFS_INT_STATUS, 32'h1, 32'h1);
    wr(OFS_INT_MASK, 32'h1);
    expect_out("irq", IRQB | LAMP, 0, 5);
    note("ack", {20'h00000, IRQB}, {33{1'b1}});
    i_vw_crew_model.tap(BTN_ACK);
    settle(T);
    wr(OFS_INT_STATUS, 32'h1);
    expect_out("irq clear", 13'h0000, 0, 5);
    wr(OFS_INT_MASK, 32'h0);
    // Unanswered alarm, then lockout before recovery
    expect_out("alarm", LAMP, 58 * T, 4 * T);
    expect_out("penalty", PEN, 6 * T, 3 * T);
    repeat (60 * T) @(posedge pclk);
    i_vw_crew_model.set_btn(BTN_PEDAL, 1'b0);
    i_vw_crew_model.recover();
    repeat (120 * T) @(posedge pclk);
    note("recovered", 33'h0, {33{1'b1}});
    i_vw_crew_model.recover();
    settle(T);
    rd("events", OFS_INT_STATUS, 32'hF, 32'hF);
    rd("dead-man", OFS_STATUS, 32'h4, 32'h4);
    // Dead-man: sanding and throttle must not reset
    repeat (20 * T) @(posedge pclk);
    i_vw_crew_model.tap(BTN_SAND);
    i_vw_crew_model.set_thr(8'h10);
    expect_out("dead-man alarm", LAMP, 36 * T, 5 * T);
    note("green ack", 33'h0, {33{1'b1}});
    i_vw_crew_model.tap(BTN_RESET);
    settle(T);
    finish_test();
  end
  // Hang guard, well beyond the planned run
  initial begin
    repeat (900 * T) @(posedge pclk);
    failures++;
    finish_test();
  end
endmodule
